/* File: hdl/nfc_host_port.sv */
// Host-side sequencer that drives the flash strobes, bus and watches ready/busy.
`timescale 1ns/100ps
module nfc_host_port import nfc_pkg::*; #(
  parameter int PROG_MAX_CYC = CACHE_PROG_CYC,
  parameter int ERASE_MAX_CYC = BLOCK_WIPE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire nfc_req_t req,
  input wire logic wp_allow,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output nfc_rsp_t rsp,
  output logic cle_ff,
  output logic ale_ff,
  output logic chip_sel_n_ff,
  output logic write_strobe_n_ff,
  output logic output_strobe_n_ff,
  output logic write_protect_n_ff,
  input wire logic [7:0] shared_bus_lines_i,
  output logic [7:0] shared_bus_lines_o_ff,
  output logic shared_bus_lines_oe_ff,
  input wire logic ready_busy_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic rdy_s1_ff, rdy_s2_ff;
  logic [7:0] bus_s1_ff, bus_s2_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_s1_ff <= 1'b1;
      rdy_s2_ff <= 1'b1;
      bus_s1_ff <= 8'h00;
      bus_s2_ff <= 8'h00;
    end else begin
      rdy_s1_ff <= ready_busy_n;
      rdy_s2_ff <= rdy_s1_ff;
      bus_s1_ff <= shared_bus_lines_i;
      bus_s2_ff <= bus_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------
  nfc_state_t st_ff, nxt_st;
  nfc_req_t cur_ff, nxt_cur;
  logic [TIMER_W-1:0] tmr_ff, nxt_tmr;
  logic to_ff, nxt_to;
  logic cle_n, ale_n, cs_n, we_n, re_n, oe_n;
  logic [7:0] dout_n;
  logic buf_in_ready, buf_in_valid;
  logic [8:0] buf_out;
  logic wait_done;
  logic [7:0] push_byte;

  // A wait op is taken as done only after the busy edge window has passed, since the
  // device may take up to 100 ns to pull the line low after the confirm strobe.
  assign wait_done = rdy_s2_ff && (tmr_ff > TIMER_W'(BUSY_ONSET_CYC));
  // The device lets go of the bus soon after the strobe rises, so a stalled push
  // must offer its own copy of the byte and not the live synchroniser.
  assign push_byte = (tmr_ff == TIMER_RST) ? bus_s2_ff : cur_ff.data;
  assign req_ready = (st_ff == NFC_IDLE);

  always_comb begin
    nxt_st = st_ff;
    nxt_cur = cur_ff;
    nxt_tmr = tmr_ff;
    nxt_to = to_ff;
    cle_n = cle_ff;
    ale_n = ale_ff;
    cs_n = chip_sel_n_ff;
    we_n = write_strobe_n_ff;
    re_n = output_strobe_n_ff;
    oe_n = shared_bus_lines_oe_ff;
    dout_n = shared_bus_lines_o_ff;
    buf_in_valid = 1'b0;
    case (st_ff)
      NFC_IDLE: begin
        if (req_valid) begin
          nxt_cur = req;
          nxt_tmr = TIMER_RST;
          nxt_to = 1'b0;
          cs_n = 1'b0;
          cle_n = (req.op == NFC_OP_CMD);
          ale_n = (req.op == NFC_OP_ADDR);
          // Bytes pass as given; command order and page reuse are the requester's duty.
          dout_n = req.data;
          // Drive only once the read strobe is high, so both ends never fight.
          oe_n = (req.op == NFC_OP_CMD) || (req.op == NFC_OP_ADDR) ||
                 (req.op == NFC_OP_WRITE);
          nxt_st = (req.op == NFC_OP_WAIT) ? NFC_WAIT : NFC_SETUP;
        end
      end
      NFC_SETUP: begin
        if (cur_ff.op == NFC_OP_READ) begin
          re_n = 1'b0;
        end else begin
          we_n = 1'b0;
        end
        nxt_st = NFC_STROBE;
      end
      NFC_STROBE: begin
        // Rising write strobe latches the byte while the latch enables still stand.
        we_n = 1'b1;
        nxt_st = (cur_ff.op == NFC_OP_READ) ? NFC_SAMPLE : NFC_HOLD;
      end
      NFC_SAMPLE: begin
        // Sampling two cycles after the fall covers access delay plus synchroniser.
        re_n = 1'b1;
        nxt_st = NFC_PUSH;
      end
      NFC_PUSH: begin
        if (tmr_ff == TIMER_RST) begin
          nxt_cur.data = bus_s2_ff;
          nxt_tmr = tmr_ff + 1'b1;
        end
        buf_in_valid = 1'b1;
        if (buf_in_ready) begin
          nxt_st = NFC_HOLD;
        end
      end
      NFC_HOLD: begin
        cle_n = 1'b0;
        ale_n = 1'b0;
        oe_n = 1'b0;
        nxt_st = NFC_IDLE;
      end
      NFC_WAIT: begin
        nxt_tmr = tmr_ff + 1'b1;
        // Busy bound is the op's own maximum; data bits carry which one.
        if (wait_done) begin
          nxt_st = NFC_PUSH;
        end else if (tmr_ff >= limit(cur_ff.data)) begin
          nxt_to = 1'b1;
          nxt_st = NFC_PUSH;
        end
      end
      default: begin
        nxt_st = NFC_IDLE;
      end
    endcase
  end

  // Standby is safe only when ready; chip select stays low through a wait.
  function automatic logic [TIMER_W-1:0] limit(input logic [7:0] code);
    case (code)
      CMD_READ_GO: limit = TIMER_W'(PAGE_FETCH_CYC);
      CMD_CACHE_NEXT, CMD_CACHE_LAST: limit = TIMER_W'(CACHED_READ_CYC);
      CMD_COPY_GO: limit = TIMER_W'(PAGE_COPY_CYC);
      CMD_PROG_MID: limit = TIMER_W'(MULTI_CACHE_CYC);
      CMD_PROG_CACHE, CMD_PROG_GO: limit = TIMER_W'(PROG_MAX_CYC);
      default: limit = TIMER_W'(ERASE_MAX_CYC);
    endcase
  endfunction : limit

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= NFC_IDLE;
      cur_ff <= '0;
      tmr_ff <= TIMER_RST;
      to_ff <= 1'b0;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      chip_sel_n_ff <= 1'b1;
      write_strobe_n_ff <= 1'b1;
      output_strobe_n_ff <= 1'b1;
      shared_bus_lines_oe_ff <= 1'b0;
      shared_bus_lines_o_ff <= 8'h00;
      write_protect_n_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cur_ff <= nxt_cur;
      tmr_ff <= nxt_tmr;
      to_ff <= nxt_to;
      cle_ff <= cle_n;
      ale_ff <= ale_n;
      chip_sel_n_ff <= cs_n;
      write_strobe_n_ff <= we_n;
      output_strobe_n_ff <= re_n;
      shared_bus_lines_oe_ff <= oe_n;
      shared_bus_lines_o_ff <= dout_n;
      write_protect_n_ff <= wp_allow;
    end
  end

  // ----------------------------------------------------------------
  // Response buffer for read data and wait results; a stalled receiver holds the sequencer in push once both entries fill.
  // ----------------------------------------------------------------
  nfc_skid_buf #(.WIDTH(9), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({(cur_ff.op == NFC_OP_WAIT) ? 8'h00 : push_byte, to_ff}),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(buf_out)
  );
  assign rsp = buf_out;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  no_contend_a: assert property (@(posedge clk) disable iff (rst)
    !(shared_bus_lines_oe_ff && !output_strobe_n_ff)) else $error("bus driven during read");
  cmd_latch_a: assert property (@(posedge clk) disable iff (rst)
    $rose(write_strobe_n_ff) |-> cle_ff || ale_ff || shared_bus_lines_oe_ff)
    else $error("write strobe rose with no qualifier");
  addr_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(cle_ff && ale_ff)) else $error("both latch enables high");
  strobe_one_a: assert property (@(posedge clk) disable iff (rst)
    $fell(output_strobe_n_ff) |=> !output_strobe_n_ff ##1 $rose(output_strobe_n_ff))
    else $error("read strobe low too long");
  cs_busy_a: assert property (@(posedge clk) disable iff (rst)
    st_ff == NFC_WAIT |-> !chip_sel_n_ff) else $error("select dropped in wait");
  wait_bound_a: assert property (@(posedge clk) disable iff (rst)
    st_ff == NFC_WAIT && tmr_ff >= limit(cur_ff.data) |=> st_ff != NFC_WAIT)
    else $error("wait exceeded its bound");
  fetch_lim_a: assert property (@(posedge clk) disable iff (rst)
    st_ff == NFC_WAIT && cur_ff.data == CMD_READ_GO |-> tmr_ff <= TIMER_W'(PAGE_FETCH_CYC))
    else $error("page fetch wait too long");
  wp_follow_a: assert property (@(posedge clk) disable iff (rst)
    ##1 write_protect_n_ff == $past(wp_allow)) else $error("protect pin lags");
  cov_read_c: cover property (@(posedge clk) disable iff (rst) st_ff == NFC_SAMPLE);
  cov_wait_c: cover property (@(posedge clk) disable iff (rst) st_ff == NFC_WAIT && wait_done);
  cov_stall_c: cover property (@(posedge clk) disable iff (rst) st_ff == NFC_PUSH && !buf_in_ready);

endmodule : nfc_host_port

/* File: pkg/nfc_pkg.sv */
// Shared constants, command codes, states and carrier types of the flash command port.
package nfc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PAGE_FETCH_TIME_US = 25;
  localparam int CACHED_READ_BUSY_US = 25;
  localparam int PAGE_COPY_BUSY_US = 30;
  localparam int MULTI_PAGE_CACHE_BUSY_US = 10;
  localparam int CACHE_PROGRAM_BUSY_US = 700;
  localparam int BLOCK_WIPE_TIME_US = 5000;
  localparam int PAGE_FETCH_CYC = (PAGE_FETCH_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CACHE_PROG_CYC = (CACHE_PROGRAM_BUSY_US * 1000) / CLK_PERIOD_NS;
  localparam int BLOCK_WIPE_CYC = (BLOCK_WIPE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CACHED_READ_CYC = (CACHED_READ_BUSY_US * 1000) / CLK_PERIOD_NS;
  localparam int PAGE_COPY_CYC = (PAGE_COPY_BUSY_US * 1000) / CLK_PERIOD_NS;
  localparam int MULTI_CACHE_CYC = (MULTI_PAGE_CACHE_BUSY_US * 1000) / CLK_PERIOD_NS;
  localparam int BUSY_ONSET_CYC = 3;
  localparam int TIMER_W = 24;
  localparam logic [TIMER_W-1:0] TIMER_RST = 24'h00_0000;
  localparam int PARTIAL_PROG_MAX = 4;
  localparam int RDY_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Command codes.
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_COPY_GO = 8'h3A;
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_MULTI_IN = 8'h81;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_PROG_MID = 8'h11;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam int STATUS_READY_BIT = 6;

  // ----------------------------------------------------------------
  // Kinds of request and sequencer states.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NFC_OP_CMD = 3'h0,
    NFC_OP_ADDR = 3'h1,
    NFC_OP_WRITE = 3'h2,
    NFC_OP_READ = 3'h3,
    NFC_OP_WAIT = 3'h4
  } nfc_op_t;

  typedef enum logic [2:0] {
    NFC_IDLE = 3'b000,
    NFC_SETUP = 3'b001,
    NFC_STROBE = 3'b011,
    NFC_HOLD = 3'b010,
    NFC_SAMPLE = 3'b110,
    NFC_WAIT = 3'b111,
    NFC_PUSH = 3'b101
  } nfc_state_t;

  typedef struct packed {
    nfc_op_t op;
    logic [7:0] data;
  } nfc_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic timeout;
  } nfc_rsp_t;

endpackage : nfc_pkg

/* File: hdl/nfc_skid_buf.sv */
// Two-entry valid/ready buffer for the response path: read data and wait results.
`timescale 1ns/100ps
module nfc_skid_buf import nfc_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers.
  // ----------------------------------------------------------------
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];

  always_comb begin
    nxt_wr = push ? PW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd = pop ? PW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

endmodule : nfc_skid_buf

/* File: test/nfc_flash_model.sv */
// Behavioural flash device that answers the host port's strobes.
`timescale 1ns/100ps
module nfc_flash_model import nfc_pkg::*; (
  input wire logic cle,
  input wire logic ale,
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic write_protect_n,
  input wire logic [7:0] bus_in,
  input wire logic host_oe,
  input wire logic slow,
  output logic [7:0] bus_out,
  output logic dev_oe,
  output logic rb_low
);
  logic [7:0] last_cmd;
  logic [11:0] col;
  int n_addr;
  int n_prog;
  logic clash;

  initial begin
    last_cmd = CMD_READ;
    col = 12'h000;
    n_addr = 0;
    n_prog = 0;
    clash = 1'b0;
    bus_out = 8'h00;
    dev_oe = 1'b0;
    rb_low = 1'b0;
  end

  task automatic go_busy(input int ns);
    fork
      begin
        rb_low = 1'b1;
        #ns;
        rb_low = 1'b0;
      end
    join_none
  endtask : go_busy

  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && cle) begin
      last_cmd = bus_in;
      n_addr = 0;
      if (bus_in == CMD_CACHE_NEXT) col = 12'h000;
      if (bus_in inside {CMD_READ_GO, CMD_CACHE_NEXT, CMD_CACHE_LAST, CMD_COPY_GO})
        go_busy(2000);
      if (write_protect_n && bus_in inside {CMD_PROG_GO, CMD_PROG_MID, CMD_PROG_CACHE}) begin
        n_prog = n_prog + 1;
        // A slow part overruns the short bound, so the host's timeout is reached.
        go_busy(slow ? 12000 : 2000);
      end
    end else if (!chip_sel_n && ale) begin
      if (n_addr == 0) col[7:0] = bus_in;
      if (n_addr == 1) col[11:8] = bus_in[3:0];
      n_addr = n_addr + 1;
    end
  end

  // Extended output ends on a rising latch or select, or a falling write strobe.
  always @(posedge cle or posedge ale or posedge chip_sel_n or negedge write_strobe_n)
    dev_oe = 1'b0;

  always @(negedge output_strobe_n) begin
    if (!chip_sel_n) begin
      #20;
      dev_oe = 1'b1;
      if (last_cmd == CMD_STATUS) bus_out = {1'b0, !rb_low, 6'h00};
      else bus_out = col[7:0] ^ 8'h5A;
      if (last_cmd != CMD_STATUS) col = col + 12'h001;
    end
  end

  // The released bus shows the inverse of the last byte so a stale sample is caught.
  always @(posedge output_strobe_n) begin
    #25;
    dev_oe = 1'b0;
    bus_out = ~bus_out;
  end

  always @(host_oe or dev_oe) begin
    if (host_oe && dev_oe) clash = 1'b1;
  end
endmodule : nfc_flash_model

/* File: test/testbench.sv */
// Self-checking bench for the flash host port against the device model.
`timescale 1ns/100ps
module testbench import nfc_pkg::*;;
  logic clk = 1'b0;
  logic rst, req_valid, req_ready, wp_allow, rsp_valid, rsp_ready, slow;
  nfc_req_t req;
  nfc_rsp_t rsp;
  logic cle, ale, cs_n, we_n, re_n, wp_n, bus_oe, dev_oe, rb_low, rb_n;
  logic [7:0] bus_o, bus_i, dev_bus;
  logic [11:0] col;
  int fail_count, n_checks, cyc;

  assign bus_i = bus_oe ? bus_o : dev_bus;
  assign rb_n = ~rb_low;
  always #50 clk = ~clk;

  nfc_host_port #(.PROG_MAX_CYC(200), .ERASE_MAX_CYC(400)) dut (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .wp_allow(wp_allow),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .cle_ff(cle), .ale_ff(ale),
    .chip_sel_n_ff(cs_n), .write_strobe_n_ff(we_n), .output_strobe_n_ff(re_n),
    .write_protect_n_ff(wp_n), .shared_bus_lines_i(bus_i), .shared_bus_lines_o_ff(bus_o),
    .shared_bus_lines_oe_ff(bus_oe), .ready_busy_n(rb_n));

  nfc_flash_model flash (.cle(cle), .ale(ale), .chip_sel_n(cs_n), .write_strobe_n(we_n),
    .output_strobe_n(re_n), .write_protect_n(wp_n), .bus_in(bus_o), .host_oe(bus_oe),
    .slow(slow), .bus_out(dev_bus), .dev_oe(dev_oe), .rb_low(rb_low));

  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A hang in either wait loop is caught by the cycle watchdog below.
  task automatic send(input nfc_op_t op, input logic [7:0] d);
    while (req_ready !== 1'b1) begin
      @(negedge clk);
    end
    req_valid = 1'b1;
    req = '{op, d};
    @(negedge clk);
    req_valid = 1'b0;
  endtask : send

  task automatic get(input logic [8:0] e);
    while (rsp_valid !== 1'b1) begin
      @(negedge clk);
    end
    chk(rsp, e);
    @(negedge clk);
  endtask : get

  function automatic logic [8:0] rd_exp(input logic [11:0] c);
    return {c[7:0] ^ 8'h5A, 1'b0};
  endfunction : rd_exp

  task automatic wt(input logic [7:0] code, input logic to);
    send(NFC_OP_WAIT, code);
    get({8'h00, to});
  endtask : wt

  task automatic addr5(input logic [11:0] c);
    send(NFC_OP_ADDR, c[7:0]);
    send(NFC_OP_ADDR, {4'h0, c[11:8]});
    repeat (2) send(NFC_OP_ADDR, 8'($urandom_range(0, 255)));
    send(NFC_OP_ADDR, 8'($urandom_range(0, 1)));
  endtask : addr5

  // Each program goes to a random page, and only four of the five reach the device, so no page sees over four partial programs.
  task automatic prog(input logic [7:0] first, input logic [7:0] conf, input logic to);
    send(NFC_OP_CMD, first);
    addr5(12'($urandom_range(0, 2047)));
    send(NFC_OP_WRITE, 8'($urandom_range(0, 255)));
    send(NFC_OP_CMD, conf);
    wt(conf, to);
  endtask : prog

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    wp_allow = 1'b0;
    rsp_ready = 1'b1;
    slow = 1'b0;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(78944));
    repeat (8) @(negedge clk);
    chk({cs_n, we_n, re_n, cle, ale, wp_n, bus_oe, rsp_valid, 1'b0}, 9'h1C0);
    rst = 1'b0;
    @(negedge clk);
    col = 12'($urandom_range(0, 2045));
    addr5(col);
    send(NFC_OP_CMD, CMD_READ_GO);
    wt(CMD_READ_GO, 1'b0);
    chk({1'b0, flash.last_cmd}, {1'b0, CMD_READ_GO});
    chk(9'(flash.col), 9'(col));
    rsp_ready = 1'b0;
    repeat (3) send(NFC_OP_READ, 8'h00);
    repeat (12) @(negedge clk);
    chk({7'h00, rsp_valid, req_ready}, 9'h002);
    rsp_ready = 1'b1;
    for (int i = 0; i < 3; i++) get(rd_exp(col + 12'(i)));
    $display("test power_on_read done");
    send(NFC_OP_CMD, CMD_CACHE_NEXT);
    wt(CMD_CACHE_NEXT, 1'b0);
    send(NFC_OP_READ, 8'h00);
    get(rd_exp(12'h000));
    send(NFC_OP_CMD, CMD_CACHE_LAST);
    wt(CMD_CACHE_LAST, 1'b0);
    send(NFC_OP_CMD, CMD_READ);
    addr5(col);
    send(NFC_OP_CMD, CMD_COPY_GO);
    wt(CMD_COPY_GO, 1'b0);
    $display("test cached_read done");
    prog(CMD_SERIAL_IN, CMD_PROG_GO, 1'b0);
    chk({8'h00, wp_n}, 9'h000);
    chk(9'(flash.n_prog), 9'h000);
    wp_allow = 1'b1;
    prog(CMD_SERIAL_IN, CMD_PROG_CACHE, 1'b0);
    prog(CMD_SERIAL_IN, CMD_PROG_GO, 1'b0);
    slow = 1'b1;
    prog(CMD_SERIAL_IN, CMD_PROG_MID, 1'b1);
    slow = 1'b0;
    prog(CMD_MULTI_IN, CMD_PROG_CACHE, 1'b0);
    send(NFC_OP_CMD, CMD_STATUS);
    send(NFC_OP_READ, 8'h00);
    get({8'h40, 1'b0});
    send(NFC_OP_CMD, CMD_RESET);
    wt(CMD_RESET, 1'b0);
    chk(9'(flash.n_prog), 9'h004);
    chk({8'h00, flash.clash}, 9'h000);
    $display("test program done");
    final_report();
  end
endmodule : testbench
